/* verilog/tws_params.svh */
/*
 * constants for the two-word burst sram port: widths, latencies, fifo depth,
 * reset levels.
 * assumes it is included by bare name from the package and the sram port module.
 */
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// ==========================================================================
// organisation
`define TWS_DATA_W        36
`define TWS_BYTE_W        9
`define TWS_BYTES_WIDE    4
`define TWS_BYTES_NARROW  2
`define TWS_ADDR_W        22

// ==========================================================================
// read latency in positive clock rises
`define TWS_LAT_PLL_ON    2
`define TWS_LAT_PLL_OFF   1

// ==========================================================================
// read fifo and reset levels
`define TWS_FIFO_DEPTH    4
`define TWS_RST_CLK_LVL   1'h1
`define TWS_RST_OE_N      1'h1

`endif

/* verilog/tws_pkg.sv */
/*
 * types shared by the sram port, the controller model and the bench.
 * assumes tws_params.svh is on the include path.
 */
`include "tws_params.svh"

package tws_pkg;

  typedef logic [`TWS_DATA_W-1:0] tws_word_t;

  // one read burst: both words travel together through the fifo
  typedef struct packed {
    tws_word_t first;
    tws_word_t second;
  } tws_burst_s;

endpackage

/* verilog/tws_fifo.sv */
/*
 * small synchronous fifo, valid/ready on both sides.
 * assumes one clock, asynchronous active-low reset and a clock enable.
 */
`timescale 1ns/1ns

module tws_fifo #(
  parameter int W     = 72,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // ========================================================================
  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // ========================================================================
  // pointers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* verilog/tws_sram_port.sv */
/*
 * two-word burst synchronous sram port: shared address, separate read and
 * write ports, both burst words on rises of the input clock pair.
 * assumes the input clock pair arrives as levels synchronous to clk, which
 * samples them several times per half period.
 */
`timescale 1ns/1ns
`include "tws_params.svh"

module tws_sram_port
  import tws_pkg::*;
#(
  parameter int ADDR_W = `TWS_ADDR_W,
  parameter bit WIDE   = 1'b1,
  parameter int DEPTH  = `TWS_FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  // input clock pair and pll control
  input  wire logic                   k_clk,
  input  wire logic                   k_clk_n,
  input  wire logic                   pll_disable_n,
  // command and write data
  input  wire logic                   read_port_select_n,
  input  wire logic                   write_port_select_n,
  input  wire logic [ADDR_W-1:0]      addr,
  input  wire tws_word_t              wr_data,
  input  wire logic [`TWS_BYTES_WIDE-1:0] byte_write_select_n,
  // read data
  output tws_word_t                   rd_data,
  output logic                        rd_data_oe_n,
  output logic                        read_valid,
  output logic                        read_ready,
  output logic                        echo_clock,
  output logic                        echo_clock_n
);

  localparam int NB = WIDE ? `TWS_BYTES_WIDE : `TWS_BYTES_NARROW;

  tws_word_t          mem [0:(2**ADDR_W)-1];
  logic               k_prev;
  logic               kn_prev;
  logic               k_evt;
  logic               kn_evt;
  logic               wr_go;
  logic               rd_go;
  logic               wr_second;
  logic               rd_second;
  logic [ADDR_W-1:0]  wr_addr;
  logic [ADDR_W-1:0]  rd_addr;
  logic [ADDR_W-1:0]  next_wr_addr;
  logic [ADDR_W-1:0]  next_rd_addr;
  logic               wr_fire;
  tws_word_t          wr_old;
  tws_word_t          wr_merged;
  tws_word_t          rd_word;
  tws_word_t          first_word;
  logic [1:0]         launch_sh;
  logic               deliver;
  logic               pend_second;
  tws_word_t          held_second;
  tws_burst_s         fifo_in;
  tws_burst_s         fifo_out;
  logic               fifo_valid;
  logic               push;
  logic               pll_on;

  // ========================================================================
  // input clock rises; parked-high clocks give no edge at all
  assign k_evt  = ce && k_clk && !k_prev;
  assign kn_evt = ce && k_clk_n && !kn_prev;
  assign pll_on = pll_disable_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      k_prev       <= `TWS_RST_CLK_LVL;
      kn_prev      <= `TWS_RST_CLK_LVL;
      echo_clock   <= `TWS_RST_CLK_LVL;
      echo_clock_n <= `TWS_RST_CLK_LVL;
    end else if (ce) begin
      k_prev       <= k_clk;
      kn_prev      <= k_clk_n;
      echo_clock   <= k_clk;
      echo_clock_n <= k_clk_n;
    end
  end

  // ========================================================================
  // command decode; both selects high starts nothing
  assign wr_go = k_evt && !write_port_select_n;
  // a full read fifo refuses the read rather than lose a burst
  assign rd_go = k_evt && !read_port_select_n && read_ready;
  assign next_wr_addr = wr_go ? addr : wr_addr + 1'b1;
  assign next_rd_addr = rd_go ? addr : rd_addr + 1'b1;
  assign wr_fire = wr_go || (kn_evt && wr_second);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_second <= 1'b0;
      rd_second <= 1'b0;
      wr_addr   <= '0;
      rd_addr   <= '0;
    end else begin
      if (wr_go) begin
        wr_second <= 1'b1;
        wr_addr   <= addr;
      end else if (kn_evt && wr_second) begin
        wr_second <= 1'b0;
      end
      if (rd_go) begin
        rd_second <= 1'b1;
        rd_addr   <= addr;
      end else if (kn_evt && rd_second) begin
        rd_second <= 1'b0;
      end
    end
  end

  // ========================================================================
  // byte-masked write, selects taken with each beat
  always_comb begin
    wr_old    = mem[next_wr_addr];
    wr_merged = wr_old;
    for (int i = 0; i < NB; i++) begin
      if (!byte_write_select_n[i]) begin
        wr_merged[i*`TWS_BYTE_W +: `TWS_BYTE_W] =
          wr_data[i*`TWS_BYTE_W +: `TWS_BYTE_W];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wr_fire) begin
      mem[next_wr_addr] <= wr_merged;
    end
  end

  // same-edge collision forwards the word being written
  assign rd_word = (wr_fire && next_wr_addr == next_rd_addr)
                 ? wr_merged : mem[next_rd_addr];

  // ========================================================================
  // burst assembly: word one at the positive rise, pushed with word two
  assign push = kn_evt && rd_second;
  assign fifo_in = '{first: first_word, second: rd_word};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_word <= '0;
    end else if (rd_go) begin
      first_word <= rd_word;
    end
  end

  tws_fifo #(
    .W     ($bits(tws_burst_s)),
    .DEPTH (DEPTH)
  ) u_rd_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (read_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_valid),
    .out_ready (deliver),
    .out_data  (fifo_out)
  );

  // ========================================================================
  // latency pipeline, counted in positive rises
  assign deliver = k_evt && fifo_valid
                 && (pll_on ? launch_sh[1] : launch_sh[0]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      launch_sh <= 2'h0;
    end else if (k_evt) begin
      launch_sh <= {launch_sh[0], rd_go};
    end
  end

  // ========================================================================
  // output drive: tri-stated except in periods that deliver a read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data      <= '0;
      held_second  <= '0;
      pend_second  <= 1'b0;
      rd_data_oe_n <= `TWS_RST_OE_N;
    end else begin
      if (deliver) begin
        rd_data      <= fifo_out.first;
        held_second  <= fifo_out.second;
        pend_second  <= 1'b1;
        rd_data_oe_n <= 1'b0;
      end else if (k_evt) begin
        rd_data_oe_n <= 1'b1;
      end
      if (kn_evt && pend_second) begin
        rd_data     <= held_second;
        pend_second <= 1'b0;
      end
    end
  end

  // valid leads data by the half period between the two rises
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      read_valid <= 1'b0;
    end else if (kn_evt) begin
      read_valid <= pll_on ? launch_sh[1] : launch_sh[0];
    end
  end

  // ========================================================================
  // checks
  sequence s_pos_rise;
    k_evt;
  endsequence

  sequence s_neg_rise;
    kn_evt;
  endsequence

  AST_LAT_TWO: assert property (@(posedge clk) disable iff (!rst_b)
    s_pos_rise ##0 (pll_on && launch_sh[1] && fifo_valid)
    |=> !rd_data_oe_n && rd_data == $past(fifo_out.first))
    else $error("read word one not delivered at latency two");

  AST_LAT_ONE: assert property (@(posedge clk) disable iff (!rst_b)
    s_pos_rise ##0 (!pll_on && launch_sh[0] && fifo_valid)
    |=> !rd_data_oe_n)
    else $error("read word one not delivered at latency one");

  AST_SECOND_WORD: assert property (@(posedge clk) disable iff (!rst_b)
    s_neg_rise ##0 pend_second |=> rd_data == $past(held_second))
    else $error("read word two not delivered on negative rise");

  AST_BURST_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
    s_neg_rise ##0 wr_second |-> next_wr_addr == wr_addr + 1'b1)
    else $error("second write beat not at next address");

  AST_RESET_HIZ: assert property (@(posedge clk)
    $rose(rst_b) |-> rd_data_oe_n && !read_valid)
    else $error("outputs driven after reset");

  AST_NOP: assert property (@(posedge clk) disable iff (!rst_b)
    s_pos_rise ##0 (read_port_select_n && write_port_select_n
      && !wr_second && !rd_second) |=> !wr_second && !rd_second)
    else $error("access started while deselected");

  AST_STOPPED: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(rd_data) && $stable(rd_data_oe_n) && $stable(read_valid))
    else $error("outputs moved while frozen");

  AST_MASK_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    wr_fire && byte_write_select_n[0]
    |-> wr_merged[`TWS_BYTE_W-1:0] == wr_old[`TWS_BYTE_W-1:0])
    else $error("deselected byte was changed");

  AST_MASK_TOP: assert property (@(posedge clk) disable iff (!rst_b)
    wr_fire && !byte_write_select_n[NB-1]
    |-> wr_merged[NB*`TWS_BYTE_W-1 -: `TWS_BYTE_W]
        == wr_data[NB*`TWS_BYTE_W-1 -: `TWS_BYTE_W])
    else $error("selected top byte not written");

  AST_FORWARD: assert property (@(posedge clk) disable iff (!rst_b)
    rd_go && wr_go && next_rd_addr == next_wr_addr
    |=> first_word == $past(wr_merged))
    else $error("collision did not forward newest data");

  AST_VALID_LEAD: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(read_valid) |-> rd_data_oe_n || pend_second)
    else $error("read valid did not lead the data");

endmodule

/* verif/tws_ctrl_model.sv */
/* memory controller model: makes the input clock pair and drives
   selects, address, write data and byte selects of the sram port.
   assumes the bench calls kcyc once per input clock period. */
`timescale 1ns/1ns

module tws_ctrl_model
  import tws_pkg::*;
#(
  parameter int AW = 6
) (
  // system clock
  input  wire logic      clk,
  // to the port
  output logic           k_clk,
  output logic           k_clk_n,
  output logic           read_port_select_n,
  output logic           write_port_select_n,
  output logic [AW-1:0]  addr,
  output tws_word_t      wr_data,
  output logic [3:0]     byte_write_select_n,
  // from the port
  input  wire tws_word_t rd_data,
  input  wire logic      oe_n,
  input  wire logic      vld
);
  // pair rests with k low between periods, so a stop adds no rise
  initial begin
    k_clk = 1'h0;
    k_clk_n = 1'h1;
    read_port_select_n = 1'h1;
    write_port_select_n = 1'h1;
    addr = '0;
    wr_data = '0;
    byte_write_select_n = 4'hF;
  end

  // ==================
  // one period: 3 clk with k high, then 3 clk with k_n high
  task automatic kcyc(input logic r, w, input logic [AW-1:0] a,
    input tws_word_t d0, d1, input logic [3:0] b0, b1,
    output tws_word_t q0, q1, output logic o0, o1, v);
    @(posedge clk);
    k_clk <= 1'h1;
    k_clk_n <= 1'h0;
    read_port_select_n <= r;
    write_port_select_n <= w;
    addr <= a;
    wr_data <= d0;
    byte_write_select_n <= b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    q0 = rd_data;
    o0 = oe_n;
    @(posedge clk);
    k_clk <= 1'h0;
    k_clk_n <= 1'h1;
    addr <= ~a;
    wr_data <= d1;
    byte_write_select_n <= b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    q1 = rd_data;
    o1 = oe_n;
    v = vld;
  endtask
endmodule

/* verif/tws_sram_port_tb.sv */
/* self-checking bench for the sram port.
   assumes tws_pkg and the controller model are compiled first. */
`timescale 1ns/1ns

module tws_sram_port_tb
  import tws_pkg::*;
;
  localparam int AW = 6;
  logic             clk = 1'h0;
  logic             rst_b, ce, pll_n, k, kn;
  logic             read_port_select_n, write_port_select_n;
  logic [AW-1:0]    addr;
  logic [3:0]       byte_write_select_n;
  tws_word_t        wd, rd;
  logic             oe_n, vld, rdy, ec, ecn;
  tws_word_t        mem [64];
  tws_word_t        q0 [256];
  tws_word_t        q1 [256];
  logic             o0 [256];
  logic             v [256];
  int               n, errors, num_checks;

  always #5 clk = ~clk;

  tws_sram_port #(.ADDR_W(AW), .WIDE(1'b1), .DEPTH(4)) u_tws_sram_port (
    .clk(clk), .rst_b(rst_b), .ce(ce), .k_clk(k), .k_clk_n(kn),
    .pll_disable_n(pll_n), .read_port_select_n(read_port_select_n),
    .write_port_select_n(write_port_select_n), .addr(addr),
    .wr_data(wd), .byte_write_select_n(byte_write_select_n),
    .rd_data(rd), .rd_data_oe_n(oe_n),
    .read_valid(vld), .read_ready(rdy), .echo_clock(ec),
    .echo_clock_n(ecn));

  tws_ctrl_model #(.AW(AW)) u_tws_ctrl_model (
    .clk(clk), .k_clk(k), .k_clk_n(kn),
    .read_port_select_n(read_port_select_n),
    .write_port_select_n(write_port_select_n), .addr(addr), .wr_data(wd),
    .byte_write_select_n(byte_write_select_n), .rd_data(rd),
    .oe_n(oe_n), .vld(vld));

  // ==================
  task automatic check(input tws_word_t got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  function automatic void mem_wr(input logic [AW-1:0] a,
    input tws_word_t d, input logic [3:0] b);
    for (int i = 0; i < 4; i++)
      if (!b[i]) mem[a][9*i +: 9] = d[9*i +: 9];
  endfunction

  function automatic tws_word_t pat(input logic [AW-1:0] a, int s);
    return 36'h123456789 ^ {6{a}} ^ tws_word_t'(s);
  endfunction

  task automatic cyc(input logic r, w, input logic [AW-1:0] a,
    input tws_word_t d0, d1, input logic [3:0] b0, b1);
    logic o1;
    u_tws_ctrl_model.kcyc(r, w, a, d0, d1, b0, b1, q0[n], q1[n], o0[n],
      o1, v[n]);
    if (!w) begin
      mem_wr(a, d0, b0);
      mem_wr(AW'(a + 1), d1, b1);
    end
    n++;
  endtask

  // idle periods: data toggles and byte selects are low, yet nothing lands
  task automatic nop(input int c);
    repeat (c) cyc(1'h1, 1'h1, AW'(n), ~pat(0, n), pat(0, n), 4'h0, 4'h0);
  endtask

  task automatic rd_chk(input int l, lat, input logic [AW-1:0] a);
    check(q0[l+lat], mem[a], "first word");
    check(q1[l+lat], mem[AW'(a + 1)], "second word");
    check(o0[l+lat], 1'h0, "output driven");
    check(v[l+lat-1], 1'h1, "valid ahead of data");
  endtask

  // ==================
  task automatic t_reset();
    check(oe_n, 1'h1, "tri-state in reset");
    check(vld, 1'h0, "valid in reset");
    check({ec, ecn, rdy}, 3'h7, "echo and ready in reset");
    rst_b <= 1'h1;
    nop(3);
    check({o0[1], o0[2], v[2]}, 3'h6, "idle after reset");
  endtask

  task automatic t_wr_rd();
    int l;
    cyc(1'h1, 1'h0, 6'h3F, pat(1, 1), pat(2, 1), 4'h0, 4'h0);
    cyc(1'h1, 1'h0, 6'h10, pat(3, 1), pat(4, 1), 4'h0, 4'h0);
    l = n;
    cyc(1'h0, 1'h1, 6'h3F, '0, '0, 4'hF, 4'hF);
    cyc(1'h0, 1'h1, 6'h10, '0, '0, 4'hF, 4'hF);
    nop(3);
    rd_chk(l, 2, 6'h3F);
    rd_chk(l + 1, 2, 6'h10);
    check(v[l+3], 1'h0, "valid drops");
    check(o0[l+4], 1'h1, "released after burst");
  endtask

  task automatic t_bytes();
    int l;
    cyc(1'h1, 1'h0, 6'h20, pat(5, 2), pat(6, 2), 4'h0, 4'h0);
    for (int i = 0; i < 5; i++) begin
      cyc(1'h1, 1'h0, 6'h20, ~pat(7, i), ~pat(8, i),
        4'hF ^ (4'h1 << i), 4'hF ^ (4'h8 >> i));
      l = n;
      cyc(1'h0, 1'h1, 6'h20, '0, '0, 4'hF, 4'hF);
      nop(2);
      rd_chk(l, 2, 6'h20);
    end
  endtask

  task automatic t_pll_off();
    int l;
    @(posedge clk);
    pll_n <= 1'h0;
    nop(2);
    cyc(1'h1, 1'h0, 6'h05, pat(9, 3), pat(10, 3), 4'h0, 4'h0);
    l = n;
    cyc(1'h0, 1'h1, 6'h05, '0, '0, 4'hF, 4'hF);
    nop(2);
    rd_chk(l, 1, 6'h05);
    @(posedge clk);
    pll_n <= 1'h1;
    nop(2);
  endtask

  task automatic t_same_stop();
    int l;
    l = n;
    cyc(1'h0, 1'h0, 6'h08, pat(11, 4), pat(12, 4), 4'h0, 4'h0);
    nop(2);
    rd_chk(l, 2, 6'h08);
    @(posedge clk);
    ce <= 1'h0;
    repeat (5) @(posedge clk);
    ce <= 1'h1;
    repeat (20) @(posedge clk);
    check(rd, mem[6'h09], "held while stopped");
    check({oe_n, ec, ecn}, 3'h1, "pins held while stopped");
    // a read issued while frozen must leave no trace once enabled again
    ce <= 1'h0;
    l = n;
    cyc(1'h0, 1'h1, 6'h3F, '0, '0, 4'hF, 4'hF);
    @(posedge clk);
    ce <= 1'h1;
    nop(3);
    check({o0[l], o0[l+2], v[l+1]}, 3'h2, "frozen read ignored");
  endtask

  // ==================
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_of_test();
  end

  initial begin
    rst_b = 1'h0;
    ce = 1'h1;
    pll_n = 1'h1;
    n = 0;
    errors = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    t_reset();
    t_wr_rd();
    t_bytes();
    t_pll_off();
    t_same_stop();
    end_of_test();
  end
endmodule
